/* chain_ram.v */
/*
 * Configuration RAM and datagram assembly for a chain of up to three
 * serial stepper drivers, with an Avalon-MM register/RAM slave.
 * Assumes sequencer inputs are on sys_clk; the driver data input is
 * asynchronous and is synchronised here. Serial clock is made here.
 */
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "chain_ram_regs.vh"
`default_nettype none

module chain_ram #(
   parameter MOTORS  = 3,
   parameter PHASE_W = 8
) (
   // Clock, reset, enable
   input  wire                     sys_clk,
   input  wire                     nrst,
   input  wire                     clk_en,
   // Avalon-MM slave
   input  wire [`ADDR_W-1:0]       avs_address,
   input  wire                     avs_read,
   input  wire                     avs_write,
   input  wire [31:0]              avs_writedata,
   output reg  [31:0]              avs_readdata,
   output wire                     avs_waitrequest,
   // Sequencer signals, one lane per motor except the shared tx_request
   input  wire [MOTORS*PHASE_W-1:0] ustep_phase,
   input  wire [MOTORS-1:0]        coil_a_fast_decay,
   input  wire [MOTORS-1:0]        coil_b_fast_decay,
   input  wire [MOTORS-1:0]        direction,
   input  wire [MOTORS-1:0]        step,
   input  wire                     tx_request,
   // Driver chain port
   output reg                      drv_sck,
   output reg                      drv_sdo,
   output reg                      drv_cs_n,
   input  wire                     drv_sdi,
   // State
   output wire                     tx_busy,
   output wire [1:0]               driver_chain_position
);

   // ==================================================================
   // States
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_LOW  = 4'h2;
   localparam [3:0] S_HIGH = 4'h4;
   localparam [3:0] S_END  = 4'h8;

   // ==================================================================
   // Storage
   reg [`CELL_W-1:0]     mem [0:`CELLS-1];
   reg                   ack_q;
   reg [1:0]             last_driver_index_q;
   reg [7:0]             div_q;
   reg                   pending_q;
   reg [3:0]             state_q;
   reg [6:0]             cell_q;
   reg [1:0]             motor_q;
   reg [7:0]             cnt_q;
   reg [MOTORS*`SIG_W-1:0] snap_q;
   reg                   sdi_s1_q;
   reg                   sdi_s2_q;
   reg [11:0]            rx_q;

   // ==================================================================
   // Bus decode
   wire                  req       = avs_read | avs_write;
   wire                  ram_sel   = avs_address[`REGION_BIT];
   wire [`ROW_W-1:0]     row       = avs_address[`ROW_W-1:0];
   // Rows 0..31 configuration, rows 32..63 microstep table
   wire [6:0]            even_cell = {row, 1'b0};
   wire                  wr_go     = clk_en & avs_write & ack_q;
   wire                  start_wr  = wr_go & ~ram_sel & (row == `REG_CTRL)
                                     & avs_writedata[`CTRL_START_BIT];

   // One wait cycle per access, answer on the second edge
   assign avs_waitrequest       = req & ~ack_q;
   assign tx_busy               = ~state_q[0];
   assign driver_chain_position = motor_q;

   // ==================================================================
   // Per-motor sequencer signal vector, built from the shared table
   wire [MOTORS*`SIG_W-1:0] sig;
   genvar m;
   generate
      for (m = 0; m < MOTORS; m = m + 1) begin : g_motor
         wire [PHASE_W-1:0] ph_a = ustep_phase[m*PHASE_W +: PHASE_W];
         wire [PHASE_W-1:0] ph_b = ph_a + 8'h40;
         // Odd quadrants walk the quarter wave backwards
         wire [5:0] idx_a = ph_a[6] ? ~ph_a[5:0] : ph_a[5:0];
         wire [5:0] idx_b = ph_b[6] ? ~ph_b[5:0] : ph_b[5:0];
         wire [5:0] amp_a = mem[`LUT_BASE + {1'b0, idx_a}];
         wire [5:0] amp_b = mem[`LUT_BASE + {1'b0, idx_b}];
         // Bit index equals the selection code
         assign sig[m*`SIG_W +: `SIG_W] = {
            step[m],
            direction[m],
            1'b1,
            1'b0,
            coil_b_fast_decay[m], ph_b[7], amp_b,
            coil_a_fast_decay[m], ph_a[7], amp_a
         };
      end
   endgenerate

   // ==================================================================
   // Current configuration word and the bit it selects
   wire [`CELL_W-1:0]  word      = mem[cell_q];
   wire                next_motor_flag = word[`CELL_W-1];
   wire [`CODE_W-1:0]  code      = word[`CODE_W-1:0];
   // A last index beyond the chain would read past the snapshot
   wire [1:0]          lane      = (motor_q < MOTORS) ? motor_q : 2'h0;
   wire [`SIG_W-1:0]   motor_sig = snap_q[lane*`SIG_W +: `SIG_W];
   reg                 sel_bit;

   // ==================================================================
   // Selection code decode
   always @* begin
      sel_bit = 1'b0;
      case (code)
         `CODE_ZERO: begin
            sel_bit = 1'b0;
         end
         `CODE_ONE: begin
            sel_bit = 1'b1;
         end
         `CODE_DIR: begin
            sel_bit = motor_sig[`SIG_W-2];
         end
         `CODE_STEP: begin
            sel_bit = motor_sig[`SIG_W-1];
         end
         default: begin
            // Coil codes index the lane directly; unused codes send zero
            if (!code[4]) begin
               sel_bit = motor_sig[code[3:0]];
            end
         end
      endcase
   end

   // ==================================================================
   // Avalon slave and RAM port
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q               <= 1'b0;
         avs_readdata        <= 32'h0;
         last_driver_index_q <= `CTRL_LAST_RST;
         div_q               <= `CTRL_DIV_RST;
      end else if (clk_en) begin
         ack_q <= req & ~ack_q;
         // Read data lands on the first edge, so it stands when wait drops
         if (req & ~ack_q & avs_read) begin
            if (ram_sel) begin
               avs_readdata <= {20'h0, mem[even_cell + 7'h1], mem[even_cell]};
            end else begin
               case (row)
                  `REG_CTRL:   avs_readdata <= {20'h0, div_q, 1'b0,
                                                last_driver_index_q, 1'b0};
                  `REG_STATUS: avs_readdata <= {28'h0, pending_q, motor_q,
                                                tx_busy};
                  `REG_RX:     avs_readdata <= {20'h0, rx_q};
                  default:     avs_readdata <= 32'h0;
               endcase
            end
         end
         if (wr_go & ~ram_sel & (row == `REG_CTRL)) begin
            last_driver_index_q <= avs_writedata[`CTRL_LAST_HI:`CTRL_LAST_LO];
            div_q               <= avs_writedata[`CTRL_DIV_HI:`CTRL_DIV_LO];
         end
      end
   end

   // RAM cells have no reset; software loads them before use
   always @(posedge sys_clk) begin
      if (wr_go & ram_sel) begin
         mem[even_cell]        <= avs_writedata[5:0];
         mem[even_cell + 7'h1] <= avs_writedata[11:6];
      end
   end

   // ==================================================================
   // Driver data input synchroniser
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
      end else if (clk_en) begin
         // Only the second stage is read by logic
         sdi_s1_q <= drv_sdi;
         sdi_s2_q <= sdi_s1_q;
      end
   end

   // ==================================================================
   // Datagram engine
   wire half_done = (cnt_q == 8'h0);

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= S_IDLE;
         pending_q <= 1'b0;
         cell_q    <= 7'h0;
         motor_q   <= 2'h0;
         cnt_q     <= 8'h0;
         snap_q    <= {MOTORS*`SIG_W{1'b0}};
         rx_q      <= 12'h0;
         drv_sck   <= 1'b0;
         drv_sdo   <= 1'b0;
         drv_cs_n  <= 1'b1;
      end else if (clk_en) begin
         // A new request in the start cycle stays pending
         if (tx_request | start_wr) begin
            pending_q <= 1'b1;
         end else if (state_q == S_IDLE && pending_q) begin
            pending_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               if (pending_q) begin
                  snap_q   <= sig;
                  cell_q   <= 7'h0;
                  motor_q  <= 2'h0;
                  cnt_q    <= div_q;
                  drv_cs_n <= 1'b0;
                  state_q  <= S_LOW;
               end
            end
            S_LOW: begin
               // Data is registered on the first low-half edge, div_q cycles before the rise
               drv_sdo <= sel_bit;
               if (half_done) begin
                  drv_sck <= 1'b1;
                  cnt_q   <= div_q;
                  state_q <= S_HIGH;
               end else begin
                  cnt_q <= cnt_q - 8'h1;
               end
            end
            S_HIGH: begin
               if (half_done) begin
                  drv_sck <= 1'b0;
                  // Driver data taken at the falling clock
                  rx_q    <= {rx_q[10:0], sdi_s2_q};
                  cnt_q   <= div_q;
                  // Wraps inside the lower half; no flag means no end
                  cell_q  <= {1'b0, cell_q[5:0] + 6'h1};
                  if (next_motor_flag) begin
                     if (motor_q == last_driver_index_q) begin
                        motor_q <= 2'h0;
                        state_q <= S_END;
                     end else begin
                        motor_q <= motor_q + 2'h1;
                        state_q <= S_LOW;
                     end
                  end else begin
                     state_q <= S_LOW;
                  end
               end else begin
                  cnt_q <= cnt_q - 8'h1;
               end
            end
            S_END: begin
               // Select stays low one half period after the last clock
               if (half_done) begin
                  drv_cs_n <= 1'b1;
                  drv_sdo  <= 1'b0;
                  state_q  <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h1;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* chain_ram_properties.sv */
/*
 * Concurrent checks on the datagram RAM block.
 * Assumes a single sys_clk domain with nrst active low.
 */
`timescale 1ns/1ps
`default_nettype none
module chain_ram_properties (
   // Clock and control
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic        avs_waitrequest,
   input  wire logic        tx_request,
   // Driver port and state
   input  wire logic        drv_sck,
   input  wire logic        drv_sdo,
   input  wire logic        drv_cs_n,
   input  wire logic        tx_busy,
   input  wire logic [1:0]  driver_chain_position
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ===================================
   // Sequences
   sequence idle_req;
      tx_request && !tx_busy && clk_en;
   endsequence
   sequence frame_open;
      ##[1:3] !drv_cs_n;
   endsequence
   // ===================================
   // Properties
   a_start_frame: assert property (idle_req |-> frame_open)
      else $error("frame did not open after request");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
      |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");
   a_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait raised without request");
   a_sck_idle: assert property (drv_cs_n |-> !drv_sck)
      else $error("serial clock active while deselected");
   a_busy_frame: assert property (!drv_cs_n |-> tx_busy)
      else $error("frame open while not busy");
   a_sdo_hold: assert property (drv_sck && $past(drv_sck) |-> $stable(drv_sdo))
      else $error("data changed while clock high");
   a_first_motor: assert property ($fell(drv_cs_n) |-> driver_chain_position == 2'h0)
      else $error("frame began at nonzero motor");
   a_pos_step: assert property (driver_chain_position != $past(driver_chain_position)
      |-> driver_chain_position == $past(driver_chain_position) + 2'h1
      || driver_chain_position == 2'h0)
      else $error("motor counter jumped");
   a_pos_rest: assert property (!tx_busy |-> driver_chain_position == 2'h0)
      else $error("motor counter not cleared when idle");
endmodule
bind chain_ram chain_ram_properties u_props (.sys_clk(sys_clk), .nrst(nrst),
   .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .tx_request(tx_request), .drv_sck(drv_sck),
   .drv_sdo(drv_sdo), .drv_cs_n(drv_cs_n), .tx_busy(tx_busy),
   .driver_chain_position(driver_chain_position));
`default_nettype wire

/* chain_ram_regs.vh */
/*
 * Constants for the driver chain datagram RAM: register map, field
 * positions, reset values, RAM geometry and signal selection codes.
 * Assumes inclusion by a module that uses word addressing on Avalon-MM.
 */
`ifndef CHAIN_RAM_REGS_VH
`define CHAIN_RAM_REGS_VH

// ==================================================================
// Address layout (word address, 7 bits: region select on top)
`define ADDR_W            7
`define REGION_BIT        6
`define ROW_W             6

// ==================================================================
// Register region offsets (region select low)
`define REG_CTRL          6'h00
`define REG_STATUS        6'h01
`define REG_RX            6'h02

// ==================================================================
// Control register fields
`define CTRL_START_BIT    0
`define CTRL_LAST_LO      1
`define CTRL_LAST_HI      2
`define CTRL_DIV_LO       4
`define CTRL_DIV_HI       11
`define CTRL_LAST_RST     2'h2
`define CTRL_DIV_RST      8'h10

// ==================================================================
// Status register fields
`define STAT_BUSY_BIT     0
`define STAT_POS_LO       1
`define STAT_POS_HI       2
`define STAT_PEND_BIT     3

// ==================================================================
// RAM geometry
`define CELL_W            6
`define CELLS             128
`define CFG_CELLS         64
`define LUT_BASE          7'h40

// ==================================================================
// Signal selection codes
`define CODE_W            5
`define SIG_W             20
`define CODE_ZERO         5'h10
`define CODE_ONE          5'h11
`define CODE_DIR          5'h12
`define CODE_STEP         5'h13

`endif

/* chain_ram_tb.sv */
/*
 * Self-checking bench: configures RAM over Avalon-MM, sends frames.
 * Assumes the chain model collects each frame's bits.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module chain_ram_tb;
   logic sys_clk, nrst, clk_en, avs_read, avs_write, tx_request, drv_sdi, ws, bs;
   logic [6:0] avs_address;
   logic [7:0] ph0, ph1;
   logic [5:0] ia, ib;
   logic [15:0] s16, e16;
   logic [63:0] ev;
   int en, k;
   logic [31:0] avs_writedata, avs_readdata, rs, rd;
   logic [23:0] ustep_phase;
   logic [2:0] fda, fdb, dir, stp;
   logic drv_sck, drv_sdo, drv_cs_n, avs_waitrequest, tx_busy;
   logic [1:0] pos;
   logic [63:0] rx, exp_v[$];
   int nbits, exp_n[$], bad_count, samples_checked;
   chain_ram u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ustep_phase(ustep_phase),
      .coil_a_fast_decay(fda), .coil_b_fast_decay(fdb), .direction(dir), .step(stp),
      .tx_request(tx_request), .drv_sck(drv_sck), .drv_sdo(drv_sdo),
      .drv_cs_n(drv_cs_n), .drv_sdi(drv_sdi), .tx_busy(tx_busy),
      .driver_chain_position(pos));
   drv_chain_model u_chain (.sck(drv_sck), .sdo(drv_sdo), .cs_n(drv_cs_n),
      .sdi(drv_sdi), .rx(rx), .nbits(nbits));
   // ===================================
   // Clock and settled samples
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      ws <= avs_waitrequest;
      bs <= tx_busy;
      rs <= avs_readdata;
   end
   // ===================================
   // Frame monitor takes the oldest note
   always @(posedge drv_cs_n) begin
      if (nrst && exp_n.size() > 0) begin
         en = exp_n.pop_front();
         ev = exp_v.pop_front();
         `CHECK("bit count", en, nbits)
         `CHECK("frame bits", ev, rx)
      end else if (nrst) begin
         bad_count++;
         $display("BAD frame exp none got %h", rx);
      end
   end
   task automatic finish_test;
      if (exp_n.size() != 0) bad_count++;
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Table contents used by the microstep scenario
   function automatic logic [5:0] lut_val(input int i);
      return 6'(i) ^ 6'h15;
   endfunction
   // Avalon cycle, held until waitrequest is seen low
   task automatic av(input logic w, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ws !== 1'b0 && n < 50);
      avs_write <= 0;
      avs_read <= 0;
      rd = rs;
      if (n >= 50) begin
         bad_count++;
         finish_test();
      end
      // Let an edge pass so the next call never reassigns a strobe at once
      @(posedge sys_clk);
   endtask
   // Request a frame and wait until it is over
   task automatic frame(input bit by_reg, input int nb, input logic [63:0] v);
      int n;
      exp_n.push_back(nb);
      exp_v.push_back(v);
      if (by_reg) begin
         av(1, 7'h00, 32'h00000011);
      end else begin
         tx_request <= 1;
         @(posedge sys_clk);
         tx_request <= 0;
      end
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((bs !== 1'b0 || n < 3) && n < 2000);
      if (n >= 2000) begin
         bad_count++;
         finish_test();
      end
      `CHECK("position", 2'h0, pos)
   endtask
   // ===================================
   // Main sequence
   initial begin
      {nrst, avs_read, avs_write, tx_request, avs_address, avs_writedata} = '0;
      clk_en = 1;
      void'($urandom(57));
      ustep_phase = $urandom;
      {fda, fdb, dir, stp} = $urandom;
      repeat (4) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk);
      av(1, 7'h00, 32'h00000010); // Last driver 0, divider 1
      av(0, 7'h00, '0);
      `CHECK("ctrl", 11'h008, rd[11:1])
      av(0, 7'h05, '0);
      `CHECK("unmapped", 32'h00000000, rd)
      av(1, 7'h40, 32'h00000491);
      av(1, 7'h41, 32'h00000433);
      av(0, 7'h40, '0);
      `CHECK("ram row", 12'h491, rd[11:0])
      frame(0, 3, {61'h0, 1'b1, dir[0], stp[0]});
      $display("test 1 done");
      av(1, 7'h00, 32'h00000012); // Last driver 1
      av(1, 7'h40, 32'h00000472);
      av(1, 7'h41, 32'h00000427);
      frame(0, 3, {61'h0, dir[0], 1'b1, fda[1]});
      $display("test 2 done");
      // Quarter-wave table, then all sixteen coil codes of motor 0
      for (k = 0; k < 32; k++) begin
         av(1, 7'h60 + 7'(k), {20'h0, lut_val(2 * k + 1), lut_val(2 * k)});
      end
      av(0, 7'h7f, '0);
      `CHECK("table row", {lut_val(63), lut_val(62)}, rd[11:0])
      for (k = 0; k < 8; k++) begin
         av(1, 7'h40 + 7'(k), {20'h0, k == 7, 5'(2 * k + 1), 1'b0, 5'(2 * k)});
      end
      ph0 = ustep_phase[7:0];
      ph1 = ph0 + 8'h40;
      ia = ph0[6] ? ~ph0[5:0] : ph0[5:0];
      ib = ph1[6] ? ~ph1[5:0] : ph1[5:0];
      s16 = {fdb[0], ph1[7], lut_val(ib), fda[0], ph0[7], lut_val(ia)};
      for (k = 0; k < 16; k++) begin
         e16[15 - k] = s16[k];
      end
      frame(1, 16, {48'h0, e16});
      av(0, 7'h01, '0);
      `CHECK("status", 4'h0, rd[3:0])
      $display("test 3 done");
      finish_test();
   end
endmodule
`default_nettype wire

/* drv_chain_model.sv */
/*
 * Model of the serial driver chain: collects the bits of each frame.
 * Assumes the block drives sck, sdo and cs_n; sdi has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module drv_chain_model (
   // Driver port
   input  wire logic        sck,
   input  wire logic        sdo,
   input  wire logic        cs_n,
   output logic             sdi,
   // Collected frame
   output logic [63:0]      rx,
   output int               nbits
);
   initial begin
      rx = '0;
      nbits = 0;
   end
   // ===================================
   // Receive
   always @(negedge cs_n) begin
      rx = '0;
      nbits = 0;
   end
   always @(posedge sck) begin
      if (!cs_n) begin
         rx = {rx[62:0], sdo};
         nbits++;
      end
   end
   // Pull-up when deselected, a moving pattern otherwise
   assign sdi = cs_n ? 1'b1 : rx[0] ^ nbits[0];
endmodule
`default_nettype wire
